// ==== smr_pkg.sv ====
package smr_pkg;

  // reset value and address arithmetic of the management memory base
  localparam logic [31:0] SMR_BASE_RESET = 32'h0003_0000;
  localparam logic [31:0] SMR_VECTOR_OFS = 32'h0000_8000;
  localparam logic [31:0] SMR_SAVE_TOP_OFS = 32'h0000_7FFF;
  localparam logic [31:0] SMR_SAVE_RESET = SMR_BASE_RESET + SMR_VECTOR_OFS + SMR_SAVE_TOP_OFS;
  localparam int SMR_ALIGN_BITS = 15;

  // slot offsets, relative to base + 8000h
  localparam logic [15:0] SMR_SLOT_BASE = 16'h7EF8;
  localparam logic [15:0] SMR_SLOT_REVID = 16'h7EFC;
  localparam logic [15:0] SMR_SLOT_IORST = 16'h7F00;
  localparam logic [15:0] SMR_SLOT_HALT = 16'h7F02;
  localparam logic [15:0] SMR_SLOT_TRAP = 16'h7FA4;

  // feature identifier layout
  localparam int SMR_REV_RELOC_BIT = 17;
  localparam int SMR_REV_IOTRAP_BIT = 16;
  localparam logic [15:0] SMR_REV_LEVEL = 16'h0001; // arbitrary revision level
  localparam logic [31:0] SMR_REV_WORD = {14'h0000, 1'b1, 1'b1, SMR_REV_LEVEL};

  // trap word layout
  localparam int SMR_TRAP_ADDR_LSB = 16;
  localparam int SMR_TRAP_VALID_BIT = 1;
  localparam int SMR_TRAP_DIR_BIT = 0;

  // restart slot values
  localparam logic [7:0] SMR_IORST_YES = 8'hFF;
  localparam logic [7:0] SMR_IORST_NO = 8'h00;

  typedef enum logic [3:0] {
    SMR_IDLE = 4'h0,
    SMR_SV_REV = 4'h1,
    SMR_SV_BASE = 4'h3,
    SMR_SV_RST = 4'h2,
    SMR_SV_HALT = 4'h6,
    SMR_SV_TRAP = 4'h7,
    SMR_IN_SMM = 4'h5,
    SMR_RD_REV = 4'h4,
    SMR_RD_BASE = 4'hC,
    SMR_RD_HALT = 4'hD,
    SMR_RD_RST = 4'hF,
    SMR_RD_WAIT = 4'hE,
    SMR_RD_DECIDE = 4'hA,
    SMR_SHUTDOWN = 4'hB
  } smr_state_e;

  typedef enum logic [1:0] {
    SMR_ACT_NEXT = 2'h0,
    SMR_ACT_AFTER_HALT = 2'h1,
    SMR_ACT_REHALT = 2'h2,
    SMR_ACT_UNPRED = 2'h3
  } smr_act_e;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic half;
    logic [31:0] addr;
    logic [31:0] data;
  } smr_slot_req_s;

  typedef struct packed {
    logic done;
    logic shutdown;
    logic ioRestart;
    smr_act_e action;
  } smr_exit_s;

endpackage : smr_pkg

// ==== smm_restart_reloc.sv ====
// Function
// R1 - base-relocation feature bit reads 1 and never changes at entry or exit.
// R2 - I/O trapping feature bit reads 1 and never changes at entry or exit.
// R3 - halt bit 0 at entry and exit: continue with next instruction.
// R4 - halt bit 1 at entry: 0 at exit resumes after halt, 1 re-halts.
// R5 - restart slot 0FFh at resume: re-execute the trapped I/O instruction.
// R6 - restart slot 00h at resume: do not re-execute the I/O instruction.
// R7 - every entry writes 00h into the I/O restart slot.
// R8 - handler sets restart slot only for interrupts on I/O instruction boundaries.
// R9 - back-to-back interrupt: handler leaves restart slot, device leaves trap word clear.
// R10 - trap word bits 31-16 hold the trapped I/O address; 15-2 reserved.
// R11 - trap word bit 1 set only for a genuine port I/O instruction.
// R12 - trap word bit 0 is direction: 1 read, 0 write.
// R13 - chipset raises the interrupt within the first access of repeated string I/O.
// R14 - without an I/O trap the address and direction fields are don't-care.
// R15 - base resets to 30000h, giving a memory range 38000h to 3FFFFh.
// R16 - misaligned base slot at resume sends the device to shutdown; the code does so only when identifier bit 17 is read as 1.
// R17 - resume latches the base slot; next interrupt uses it for save and vector.
// R18 - entry saves at current base, writes base to slot 7EF8h, then branches.
// R19 - handler entry address is base plus 8000h.
// R20 - save area starts at base plus 8000h plus 7FFFh.
// R21 - base is taken from the slot only when identifier bit 17 is set.
// R22 - entry writes halt slot bit 0: 1 after a halt, else 0.
// R23 - identifier read on every resume, fixed bits written on every save.
// R24 - base aligned only when low fifteen bits are zero, checked before commit.
module smm_restart_reloc (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic entryReq,
  input wire logic haltAtEntry,
  input wire logic ioInstrValid,
  input wire logic backToBack,
  input wire logic [15:0] trapAddrPin,
  input wire logic trapReadPin,
  input wire logic resumeReq,
  input wire logic [31:0] slotRdData,
  output smr_pkg::smr_slot_req_s slotReq,
  output smr_pkg::smr_exit_s exitInfo,
  output logic inSmm,
  output logic [31:0] entryVector,
  output logic [31:0] saveAreaStart,
  output logic [31:0] mgmtMemoryBase
);
  import smr_pkg::*;

  function automatic logic [31:0] slotAddr(input logic [31:0] base, input logic [15:0] ofs);
    slotAddr = base + SMR_VECTOR_OFS + {16'h0000, ofs};
  endfunction : slotAddr

  function automatic logic isAligned(input logic [31:0] v);
    isAligned = (v[SMR_ALIGN_BITS-1:0] == '0); // [R24]
  endfunction : isAligned

  smr_state_e state_r;
  smr_state_e state_nxt;
  smr_slot_req_s slotReq_r;
  smr_slot_req_s slotReq_nxt;
  smr_exit_s exit_r;
  logic inSmm_r;
  logic [31:0] entryVector_r;
  logic [31:0] saveAreaStart_r;
  logic [31:0] base_r;
  logic [15:0] trapAddrS1_r;
  logic [15:0] trapAddrS2_r;
  logic trapReadS1_r;
  logic trapReadS2_r;
  logic [15:0] trapAddr_r;
  logic trapRead_r;
  logic ioValid_r;
  logic backToBack_r;
  logic haltAtEntry_r;
  logic [31:0] rdRev_r;
  logic [31:0] rdBase_r;
  logic [15:0] rdHalt_r;

  // decoded values used by the save and the resume decision
  wire [31:0] trapWord = backToBack_r ? 32'h0000_0000 :
                         {trapAddr_r, 14'h0000, ioValid_r, trapRead_r};
  wire haltExit = rdHalt_r[0];
  wire relocOk = rdRev_r[SMR_REV_RELOC_BIT];
  wire baseAligned = isAligned(rdBase_r);
  wire goShutdown = relocOk && !baseAligned;
  wire ioRestartNxt = (slotRdData[7:0] == SMR_IORST_YES);
  wire [31:0] baseNxt = (relocOk && baseAligned) ? rdBase_r : base_r;
  wire smr_act_e actNxt = haltAtEntry_r ?
                          (haltExit ? SMR_ACT_REHALT : SMR_ACT_AFTER_HALT) :
                          (haltExit ? SMR_ACT_UNPRED : SMR_ACT_NEXT);

  assign slotReq = slotReq_r;
  assign exitInfo = exit_r;
  assign inSmm = inSmm_r;
  assign entryVector = entryVector_r;
  assign saveAreaStart = saveAreaStart_r;
  assign mgmtMemoryBase = base_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SMR_IDLE: if (entryReq) state_nxt = SMR_SV_REV;
      SMR_SV_REV: state_nxt = SMR_SV_BASE;
      SMR_SV_BASE: state_nxt = SMR_SV_RST;
      SMR_SV_RST: state_nxt = SMR_SV_HALT;
      SMR_SV_HALT: state_nxt = SMR_SV_TRAP;
      SMR_SV_TRAP: state_nxt = SMR_IN_SMM;
      SMR_IN_SMM: if (resumeReq) state_nxt = SMR_RD_REV;
      SMR_RD_REV: state_nxt = SMR_RD_BASE;
      SMR_RD_BASE: state_nxt = SMR_RD_HALT;
      SMR_RD_HALT: state_nxt = SMR_RD_RST;
      SMR_RD_RST: state_nxt = SMR_RD_WAIT;
      SMR_RD_WAIT: state_nxt = SMR_RD_DECIDE;
      SMR_RD_DECIDE: state_nxt = goShutdown ? SMR_SHUTDOWN : SMR_IDLE; // [R16]
      SMR_SHUTDOWN: state_nxt = SMR_SHUTDOWN;
      default: state_nxt = SMR_IDLE;
    endcase
  end

  // slot access issued one cycle after the state that asks for it
  always_comb begin
    slotReq_nxt = '0;
    unique case (state_r)
      SMR_SV_REV: begin
        slotReq_nxt.wrEn = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_REVID);
        slotReq_nxt.data = SMR_REV_WORD; // [R1] [R2] [R23]
      end
      SMR_SV_BASE: begin
        slotReq_nxt.wrEn = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_BASE);
        slotReq_nxt.data = base_r; // [R18]
      end
      SMR_SV_RST: begin
        slotReq_nxt.wrEn = 1'b1;
        slotReq_nxt.half = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_IORST);
        slotReq_nxt.data = {24'h00_0000, SMR_IORST_NO}; // [R7]
      end
      SMR_SV_HALT: begin
        slotReq_nxt.wrEn = 1'b1;
        slotReq_nxt.half = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_HALT);
        slotReq_nxt.data = {31'h0000_0000, haltAtEntry_r}; // [R22]
      end
      SMR_SV_TRAP: begin
        slotReq_nxt.wrEn = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_TRAP);
        slotReq_nxt.data = trapWord; // [R9] [R10] [R11] [R12] [R14]
      end
      SMR_RD_REV: begin
        slotReq_nxt.rdEn = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_REVID); // [R23]
      end
      SMR_RD_BASE: begin
        slotReq_nxt.rdEn = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_BASE); // [R17]
      end
      SMR_RD_HALT: begin
        slotReq_nxt.rdEn = 1'b1;
        slotReq_nxt.half = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_HALT);
      end
      SMR_RD_RST: begin
        slotReq_nxt.rdEn = 1'b1;
        slotReq_nxt.half = 1'b1;
        slotReq_nxt.addr = slotAddr(base_r, SMR_SLOT_IORST);
      end
      default: slotReq_nxt = '0;
    endcase
  end

  // chipset pins pass two flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trapAddrS1_r <= '0;
      trapAddrS2_r <= '0;
      trapReadS1_r <= 1'b0;
      trapReadS2_r <= 1'b0;
    end else if (ce) begin
      trapAddrS1_r <= trapAddrPin;
      trapAddrS2_r <= trapAddrS1_r;
      trapReadS1_r <= trapReadPin;
      trapReadS2_r <= trapReadS1_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= SMR_IDLE;
      slotReq_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      slotReq_r <= slotReq_nxt;
    end
  end

  // entry capture of the interrupted context
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trapAddr_r <= '0;
      trapRead_r <= 1'b0;
      ioValid_r <= 1'b0;
      backToBack_r <= 1'b0;
      haltAtEntry_r <= 1'b0;
    end else if (ce && state_r == SMR_IDLE && entryReq) begin
      trapAddr_r <= trapAddrS2_r; // [R10]
      trapRead_r <= trapReadS2_r; // [R12]
      ioValid_r <= ioInstrValid; // [R11]
      backToBack_r <= backToBack; // [R9]
      haltAtEntry_r <= haltAtEntry;
    end
  end

  // read data returns two states after the read is asked for
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdRev_r <= '0;
      rdBase_r <= '0;
      rdHalt_r <= '0;
    end else if (ce) begin
      if (state_r == SMR_RD_HALT) rdRev_r <= slotRdData;
      if (state_r == SMR_RD_RST) rdBase_r <= slotRdData;
      if (state_r == SMR_RD_WAIT) rdHalt_r <= slotRdData[15:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      base_r <= SMR_BASE_RESET; // [R15]
      saveAreaStart_r <= SMR_SAVE_RESET;
    end else if (ce && state_r == SMR_RD_DECIDE && !goShutdown) begin
      base_r <= baseNxt; // [R17] [R21] [R24]
      saveAreaStart_r <= baseNxt + SMR_VECTOR_OFS + SMR_SAVE_TOP_OFS; // [R20]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inSmm_r <= 1'b0;
      entryVector_r <= SMR_BASE_RESET + SMR_VECTOR_OFS;
    end else if (ce) begin
      if (state_r == SMR_SV_TRAP) begin
        inSmm_r <= 1'b1;
        entryVector_r <= base_r + SMR_VECTOR_OFS; // [R18] [R19]
      end else if (state_r == SMR_RD_DECIDE && !goShutdown) begin
        inSmm_r <= 1'b0;
      end
    end
  end

  // resume outcome; done is a one-cycle pulse, shutdown holds until reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exit_r <= '0;
    end else if (ce) begin
      exit_r.done <= 1'b0;
      if (state_r == SMR_RD_DECIDE) begin
        exit_r.done <= 1'b1;
        exit_r.shutdown <= goShutdown; // [R16]
        exit_r.ioRestart <= ioRestartNxt && !goShutdown; // [R5] [R6]
        exit_r.action <= actNxt; // [R3] [R4]
      end
    end
  end

  chk_rev_fixed_bits: assert property (@(posedge clock) disable iff (rst) // [R1] [R2] [R23]
    (slotReq_r.wrEn && slotReq_r.addr == slotAddr(base_r, SMR_SLOT_REVID)) |->
      (slotReq_r.data[SMR_REV_RELOC_BIT] && slotReq_r.data[SMR_REV_IOTRAP_BIT]))
    else $error("feature bits not written as 1");

  chk_restart_clear: assert property (@(posedge clock) disable iff (rst) // [R7]
    (ce && state_r == SMR_SV_RST) |=>
      (slotReq_r.wrEn && slotReq_r.data[7:0] == SMR_IORST_NO))
    else $error("restart slot not cleared at entry");

  chk_halt_slot: assert property (@(posedge clock) disable iff (rst) // [R22]
    (ce && state_r == SMR_SV_HALT) |=>
      (slotReq_r.wrEn && slotReq_r.data[0] == haltAtEntry_r))
    else $error("halt slot does not match interrupted halt");

  chk_io_restart: assert property (@(posedge clock) disable iff (rst) // [R5] [R6]
    (ce && state_r == SMR_RD_DECIDE && !goShutdown) |=>
      (exit_r.done && exit_r.ioRestart == ($past(slotRdData[7:0]) == SMR_IORST_YES)))
    else $error("I/O restart decision wrong");

  chk_halt_action: assert property (@(posedge clock) disable iff (rst) // [R3] [R4]
    (ce && state_r == SMR_RD_DECIDE) |=>
      (exit_r.action == (haltAtEntry_r ?
        (rdHalt_r[0] ? SMR_ACT_REHALT : SMR_ACT_AFTER_HALT) :
        (rdHalt_r[0] ? SMR_ACT_UNPRED : SMR_ACT_NEXT))))
    else $error("halt restart action wrong");

  chk_shutdown_align: assert property (@(posedge clock) disable iff (rst) // [R16] [R24]
    (ce && state_r == SMR_RD_DECIDE && relocOk && rdBase_r[SMR_ALIGN_BITS-1:0] != '0) |=>
      (exit_r.shutdown && state_r == SMR_SHUTDOWN && $stable(base_r)))
    else $error("misaligned base did not shut down");

  chk_base_commit: assert property (@(posedge clock) disable iff (rst) // [R17] [R21]
    (ce && state_r == SMR_RD_DECIDE && !goShutdown) |=>
      (base_r == ($past(relocOk) ? $past(rdBase_r) : $past(base_r))))
    else $error("base not latched from slot");

  chk_entry_vector: assert property (@(posedge clock) disable iff (rst) // [R18] [R19]
    (ce && state_r == SMR_SV_TRAP) |=> (inSmm_r && entryVector_r == base_r + SMR_VECTOR_OFS))
    else $error("entry vector not base plus 8000h");

  chk_trap_word: assert property (@(posedge clock) disable iff (rst) // [R9] [R10] [R12]
    (slotReq_r.wrEn && slotReq_r.addr == slotAddr(base_r, SMR_SLOT_TRAP)) |->
      (backToBack_r ? slotReq_r.data == 32'h0000_0000 :
        (slotReq_r.data[31:SMR_TRAP_ADDR_LSB] == trapAddr_r &&
         slotReq_r.data[SMR_TRAP_DIR_BIT] == trapRead_r &&
         slotReq_r.data[SMR_TRAP_VALID_BIT] == ioValid_r)))
    else $error("trap word contents wrong");

endmodule : smm_restart_reloc

// ==== smr_slot_model.sv ====
module smr_slot_model
  import smr_pkg::*;
(
  input wire logic clock,
  input wire smr_pkg::smr_slot_req_s slotReq,
  output logic [31:0] slotRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [31:0]];

  function automatic logic [31:0] peek(input logic [31:0] addr);
    return mem.exists(addr) ? mem[addr] : 32'h0BAD_0BAD;
  endfunction : peek

  task automatic poke(input logic [31:0] addr, input logic [31:0] data);
    mem[addr] = data;
  endtask : poke

  initial begin
    slotRdData = 32'h5A5A_A5A5;
  end

  // read data stands in the cycle after the request; otherwise the bus toggles
  always @(posedge clock) begin
    if (slotReq.wrEn) begin
      mem[slotReq.addr] = slotReq.half ? {16'h0000, slotReq.data[15:0]} : slotReq.data;
    end
    slotRdData <= slotReq.rdEn ? peek(slotReq.addr) : ~slotRdData;
  end
endmodule : smr_slot_model

// ==== test_smm_restart_reloc.sv ====
module test_smm_restart_reloc;
  timeunit 1ns;
  timeprecision 1ns;
  import smr_pkg::*;
  logic clock, rst, ce, entryReq, haltAtEntry, ioInstrValid, backToBack, trapReadPin, resumeReq;
  logic [15:0] trapAddrPin;
  logic [31:0] slotRdData, entryVector, saveAreaStart, mgmtMemoryBase;
  smr_slot_req_s slotReq;
  smr_exit_s exitInfo;
  logic inSmm;
  logic [31:0] expBase;
  int numErrors, checksDone, cycles;

  smm_restart_reloc smm_restart_reloc_i (.clock(clock), .rst(rst), .ce(ce), .entryReq(entryReq),
    .haltAtEntry(haltAtEntry), .ioInstrValid(ioInstrValid), .backToBack(backToBack),
    .trapAddrPin(trapAddrPin), .trapReadPin(trapReadPin), .resumeReq(resumeReq),
    .slotRdData(slotRdData), .slotReq(slotReq), .exitInfo(exitInfo), .inSmm(inSmm),
    .entryVector(entryVector), .saveAreaStart(saveAreaStart), .mgmtMemoryBase(mgmtMemoryBase));
  smr_slot_model smr_slot_model_i (.clock(clock), .slotReq(slotReq), .slotRdData(slotRdData));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic endOfTest();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : endOfTest

  function automatic logic [31:0] slotAt(input logic [15:0] ofs);
    return expBase + SMR_VECTOR_OFS + {16'h0000, ofs};
  endfunction : slotAt

  task automatic enter(input logic halt, input logic io, input logic b2b, input logic [15:0] addr,
                       input logic rd);
    int n;
    logic [31:0] trap;
    logic [31:0] rev;
    smr_slot_model_i.poke(slotAt(SMR_SLOT_IORST), 32'h0000_00FF);
    @(posedge clock);
    trapAddrPin <= addr;
    trapReadPin <= rd;
    repeat (3) @(posedge clock);
    entryReq <= 1'b1;
    haltAtEntry <= halt;
    ioInstrValid <= io;
    backToBack <= b2b;
    @(posedge clock);
    entryReq <= 1'b0;
    n = 0;
    while (inSmm !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    check({31'h0, n < 20}, 32'h1);
    rev = smr_slot_model_i.peek(slotAt(SMR_SLOT_REVID));
    check(rev & 32'h0002_0000, 32'h0002_0000);
    check(rev & 32'h0001_0000, 32'h0001_0000);
    check(smr_slot_model_i.peek(slotAt(SMR_SLOT_BASE)), expBase);
    check(smr_slot_model_i.peek(slotAt(SMR_SLOT_IORST)), 32'h0000_0000);
    check(smr_slot_model_i.peek(slotAt(SMR_SLOT_HALT)) & 32'h1, {31'h0, halt});
    trap = smr_slot_model_i.peek(slotAt(SMR_SLOT_TRAP));
    if (b2b)
      check(trap, 32'h0000_0000);
    else if (io)
      check(trap, {addr, 14'h0000, 1'b1, rd});
    else
      check(trap & 32'h2, 32'h0);
    check(entryVector, expBase + 32'h0000_8000);
    check(saveAreaStart, expBase + 32'h0000_FFFF);
  endtask : enter

  task automatic leave(input logic haltExit, input logic [7:0] restartVal,
                       input logic [31:0] newBase, input logic idReloc, input logic [1:0] expAct,
                       input logic expRestart, input logic expShut);
    int n;
    smr_slot_model_i.poke(slotAt(SMR_SLOT_HALT), {31'h0, haltExit});
    smr_slot_model_i.poke(slotAt(SMR_SLOT_IORST), {24'h0, restartVal});
    smr_slot_model_i.poke(slotAt(SMR_SLOT_BASE), newBase);
    if (!idReloc)
      smr_slot_model_i.poke(slotAt(SMR_SLOT_REVID), SMR_REV_WORD & 32'hFFFD_FFFF);
    @(posedge clock);
    resumeReq <= 1'b1;
    @(posedge clock);
    resumeReq <= 1'b0;
    n = 0;
    while (exitInfo.done !== 1'b1 && exitInfo.shutdown !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    check({31'h0, n < 30}, 32'h1);
    check({31'h0, exitInfo.shutdown}, {31'h0, expShut});
    if (!expShut) begin
      check({30'h0, exitInfo.action}, {30'h0, expAct});
      check({31'h0, exitInfo.ioRestart}, {31'h0, expRestart});
      check({31'h0, inSmm}, 32'h0);
      if (idReloc)
        expBase = newBase;
    end
    check(mgmtMemoryBase, expBase);
  endtask : leave

  // clock enable low must freeze the block even with a resume asked for
  task automatic freeze();
    @(posedge clock);
    ce <= 1'b0;
    resumeReq <= 1'b1;
    repeat (3) @(posedge clock);
    resumeReq <= 1'b0;
    ce <= 1'b1;
    @(negedge clock);
    check({31'h0, inSmm}, 32'h1);
    check({31'h0, exitInfo.done}, 32'h0);
    check(mgmtMemoryBase, expBase);
  endtask : freeze

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      endOfTest();
    end
  end

  initial begin
    rst <= 1'b1;
    ce <= 1'b1;
    entryReq <= 1'b0;
    haltAtEntry <= 1'b0;
    ioInstrValid <= 1'b0;
    backToBack <= 1'b0;
    trapAddrPin <= 16'h0000;
    trapReadPin <= 1'b0;
    resumeReq <= 1'b0;
    expBase = 32'h0003_0000;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(mgmtMemoryBase, 32'h0003_0000);
    check(entryVector, 32'h0003_8000);
    check(saveAreaStart, 32'h0003_FFFF);
    enter(1'b0, 1'b1, 1'b0, 16'h00B2, 1'b1);
    freeze();
    leave(1'b0, 8'hFF, expBase, 1'b1, 2'h0, 1'b1, 1'b0);
    enter(1'b1, 1'b0, 1'b0, 16'h0060, 1'b0);
    leave(1'b0, 8'h00, 32'h0010_8000, 1'b1, 2'h1, 1'b0, 1'b0);
    enter(1'b1, 1'b1, 1'b0, 16'hFFFF, 1'b0);
    leave(1'b1, 8'h00, 32'h0020_0000, 1'b0, 2'h2, 1'b0, 1'b0);
    enter(1'b0, 1'b1, 1'b1, 16'h1234, 1'b1);
    leave(1'b1, 8'h00, expBase, 1'b1, 2'h3, 1'b0, 1'b0);
    enter(1'b0, 1'b0, 1'b0, 16'h0080, 1'b1);
    leave(1'b0, 8'h00, 32'h0010_4000, 1'b1, 2'h0, 1'b0, 1'b1);
    endOfTest();
  end
endmodule : test_smm_restart_reloc
